// ==== hdl/conv_pkg.sv ====
// package for the conversion mode switch block: offsets, commands, timing, states
// assumes a single 100 MHz system clock and an open-drain 2-wire bus outside
package conv_pkg;

  // ----------------------------------------------------------------
  // register map and command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CONV_CFG_HIGH_OFS = 8'hac; // conversion_config_high location
  localparam logic [7:0] CMD_START_CONV = 8'h51;    // begin temperature conversions
  localparam logic [7:0] CMD_COMMIT = 8'h48;        // copy volatile config to nonvolatile
  localparam int SEL_BIT = 0;                       // single_conversion_select position
  localparam logic [7:0] CFG_RESET = 8'h00;         // config contents after reset
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;  // bus address, value is arbitrary
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;      // data bits before the ack slot

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int COMMIT_TIME_MS = 10;               // nonvolatile commit duration
  localparam int COMMIT_CYCLES_DOC = COMMIT_TIME_MS * (SYS_CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // byte phase of the bus transaction
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, // waiting for start
    ST_ADDR = 5'h02, // receiving address byte
    ST_CMD  = 5'h04, // receiving command or location byte
    ST_DATA = 5'h08, // receiving config data byte
    ST_SKIP = 5'h10  // not addressed or nothing more expected
  } bus_state_t;

endpackage : conv_pkg

// ==== hdl/pin_sync.sv ====
// three-stage synchroniser with agreement filter for one bus pin
// assumes the pin is asynchronous to sys_clk_i
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  logic stage1_q; // metastability catcher, read only by stage2
  logic stage2_q;
  logic stage3_q;

  // ----------------------------------------------------------------
  // sampling chain; level moves only when stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1_q <= RESET_LEVEL;
      stage2_q <= RESET_LEVEL;
      stage3_q <= RESET_LEVEL;
      level_o <= RESET_LEVEL;
    end else begin
      stage1_q <= pin_i;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      if (stage2_q == stage3_q) begin
        level_o <= stage3_q;
      end
    end
  end

endmodule : pin_sync

// ==== hdl/conv_mode_switch.sv ====
// 2-wire command interpreter: config high byte write, start convert, nonvolatile commit
// assumes external pull-ups on scl/sda; sda is driven low only through sda_oe_o
`timescale 1ns/1ps
module conv_mode_switch
  import conv_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = conv_pkg::DEV_ADDR_DEFAULT,
  parameter int COMMIT_CYCLES = conv_pkg::COMMIT_CYCLES_DOC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // 2-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // device state
  output logic [7:0] config_volatile_o,
  output logic [7:0] config_nonvolatile_o,
  output logic single_conversion_select_o,
  output logic conversion_active_o,
  output logic nonvolatile_busy_flag_o
);
  import conv_pkg::*;

  localparam int CW = $clog2(COMMIT_CYCLES + 1); // busy counter width

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic scl_lvl; // filtered clock level
  logic sda_lvl; // filtered data level
  logic scl_prev_q; // previous filtered clock
  logic sda_prev_q; // previous filtered data
  bus_state_t state_q; // byte phase
  bus_state_t st_nxt; // phase after the current byte
  logic [3:0] cnt_q; // bits received in current byte
  logic [7:0] shift_q; // incoming byte, msb first
  logic ack_q; // pulling sda low in the ack slot
  logic in_ack_q; // inside the ninth clock
  logic [7:0] cfg_vol_q; // volatile working copy
  logic [7:0] cfg_nv_q; // nonvolatile contents
  logic conv_q; // conversions running
  logic busy_q; // commit in progress
  logic [CW-1:0] busy_cnt_q; // cycles left of the commit
  logic ack_ok; // byte is to be acknowledged
  logic cfg_wr; // data byte lands in volatile copy
  logic conv_go; // start conversions now
  logic commit_go; // start a commit now

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .pin_i(scl_i),
    .level_o(scl_lvl)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .pin_i(sda_i),
    .level_o(sda_lvl)
  );

  // ----------------------------------------------------------------
  // bus event decode
  // ----------------------------------------------------------------
  wire scl_rise = scl_lvl & ~scl_prev_q;
  wire scl_fall = ~scl_lvl & scl_prev_q;
  // start and stop only count while the clock stays high
  wire bus_start = scl_lvl & scl_prev_q & sda_prev_q & ~sda_lvl;
  wire bus_stop = scl_lvl & scl_prev_q & ~sda_prev_q & sda_lvl;
  // eighth bit was sampled and its clock just fell
  wire byte_done = scl_fall & (cnt_q == BITS_PER_BYTE) & ~in_ack_q;
  // ninth clock falls: ack slot ends
  wire ack_done = scl_fall & in_ack_q;
  wire addr_hit = (shift_q[7:1] == DEV_ADDR) & ~shift_q[0];
  wire is_cfg = (shift_q == CONV_CFG_HIGH_OFS);
  wire is_conv = (shift_q == CMD_START_CONV);
  wire is_commit = (shift_q == CMD_COMMIT);

  // ----------------------------------------------------------------
  // byte decision: ack and next phase
  // ----------------------------------------------------------------
  always_comb begin
    ack_ok = 1'b0;
    st_nxt = ST_SKIP;
    case (state_q)
      ST_ADDR: begin
        ack_ok = addr_hit;
        st_nxt = addr_hit ? ST_CMD : ST_SKIP;
      end
      ST_CMD: begin
        // unknown codes are left unacknowledged
        ack_ok = is_cfg | is_conv | is_commit;
        st_nxt = is_cfg ? ST_DATA : ST_SKIP;
      end
      ST_DATA: begin
        ack_ok = 1'b1;
        st_nxt = ST_SKIP;
      end
      ST_IDLE: begin
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_SKIP;
      end
    endcase
  end

  assign cfg_wr = byte_done & (state_q == ST_DATA);
  assign conv_go = byte_done & (state_q == ST_CMD) & is_conv;
  // a commit asked for while one is running is acked but dropped
  assign commit_go = byte_done & (state_q == ST_CMD) & is_commit & ~busy_q;

  // ----------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_lvl;
      sda_prev_q <= sda_lvl;
    end
  end

  // ----------------------------------------------------------------
  // byte phase; start and stop override everything
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
    end else if (bus_stop) begin
      state_q <= ST_IDLE;
    end else if (bus_start) begin
      state_q <= ST_ADDR; // repeated start restarts the address phase
    end else if (byte_done) begin
      state_q <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bit counter and shifter, msb first
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
      shift_q <= '0;
    end else if (bus_start | bus_stop) begin
      cnt_q <= '0;
    end else if (scl_rise & ~in_ack_q & (cnt_q != BITS_PER_BYTE)) begin
      cnt_q <= cnt_q + 4'h1;
      shift_q <= {shift_q[6:0], sda_lvl};
    end else if (ack_done) begin
      cnt_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // ack slot: driven from the eighth falling edge to the ninth
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_ack_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (bus_start | bus_stop | ack_done) begin
      in_ack_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (byte_done) begin
      in_ack_q <= 1'b1;
      ack_q <= ack_ok;
    end
  end

  assign sda_o = 1'b0; // open drain: only ever pulls low
  assign sda_oe_o = ack_q;

  // ----------------------------------------------------------------
  // volatile copy, conversion run flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_vol_q <= CFG_RESET;
      conv_q <= 1'b0;
    end else begin
      if (cfg_wr) begin
        cfg_vol_q <= shift_q;
      end
      if (conv_go) begin
        conv_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile store and commit timer
  // ----------------------------------------------------------------
  // the timer stands in for the slow cell write so software sees a real busy window
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_nv_q <= CFG_RESET;
      busy_q <= 1'b0;
      busy_cnt_q <= '0;
    end else if (commit_go) begin
      cfg_nv_q <= cfg_vol_q;
      busy_q <= 1'b1;
      busy_cnt_q <= CW'(COMMIT_CYCLES - 1);
    end else if (busy_q) begin
      if (busy_cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        busy_cnt_q <= busy_cnt_q - 1'b1;
      end
    end
  end

  assign config_volatile_o = cfg_vol_q;
  assign config_nonvolatile_o = cfg_nv_q;
  assign single_conversion_select_o = cfg_vol_q[SEL_BIT];
  assign conversion_active_o = conv_q;
  assign nonvolatile_busy_flag_o = busy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_addr_ack: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    byte_done && (state_q == ST_ADDR) |=> sda_oe_o == $past(addr_hit) && in_ack_q
  ) else $error("address byte ack wrong");

  chk_cfg_select: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    byte_done && (state_q == ST_CMD) && is_cfg |=> sda_oe_o && (state_q == ST_DATA)
  ) else $error("config location not selected");

  chk_nv_hold: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !commit_go |=> $stable(cfg_nv_q)
  ) else $error("nonvolatile changed without commit");

  chk_data_write: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    byte_done && (state_q == ST_DATA)
    |=> sda_oe_o && single_conversion_select_o == $past(shift_q[SEL_BIT])
  ) else $error("select bit not written");

  chk_conv_start: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    byte_done && (state_q == ST_CMD) && is_conv |=> conversion_active_o && sda_oe_o
  ) else $error("start convert not honoured");

  chk_commit_copy: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    commit_go |=> cfg_nv_q == $past(cfg_vol_q) && nonvolatile_busy_flag_o ##1 busy_q
  ) else $error("commit did not copy or flag busy");

  chk_ack_slot: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sda_oe_o |-> in_ack_q && (cnt_q == BITS_PER_BYTE)
  ) else $error("ack driven outside ninth clock");

  chk_ack_release: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    sda_oe_o && scl_fall |=> !sda_oe_o
  ) else $error("ack not released after ninth clock");

endmodule : conv_mode_switch

// ==== sim/bus_master.sv ====
// 2-wire bus controller model: start, stop and byte writes with ack sampling
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
module bus_master #(
  parameter int HALF = 10 // sys clocks per bus phase, well above the filter delay
) (
  // clock
  input wire logic sys_clk_i,
  // bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ----------------------------------------------------------------
  // bus primitives
  // ----------------------------------------------------------------
  initial begin
    scl_o = 1'b1; // idle bus, both lines released
    sda_low_o = 1'b0;
  end

  // every level is held a full phase so scl and sda never move together
  task automatic hold();
    repeat (HALF) @(negedge sys_clk_i);
  endtask : hold

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_low_o = 1'b0;
    hold();
    scl_o = 1'b1;
    hold();
    sda_low_o = 1'b1;
    hold();
    scl_o = 1'b0;
    hold();
  endtask : start

  // stop: sda rises while scl is high, bus left released
  task automatic stop();
    sda_low_o = 1'b1;
    hold();
    scl_o = 1'b1;
    hold();
    sda_low_o = 1'b0;
    hold();
  endtask : stop

  // one clock pulse; the line is sampled at the end of the high phase
  task automatic clock_bit(input logic v, output logic seen);
    sda_low_o = ~v;
    hold();
    scl_o = 1'b1;
    hold();
    seen = sda_i;
    scl_o = 1'b0;
    hold();
  endtask : clock_bit

  // eight data bits then the ack slot with sda released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], seen);
    end
    clock_bit(1'b1, seen);
    ack = ~seen; // a pulled-low line is an ack
  endtask : send_byte
endmodule : bus_master

// ==== sim/tb_top.sv ====
// self-checking bench for the conversion mode switch block
// assumes conv_pkg and the design files are compiled first
`timescale 1ns/1ps
module tb_top;
  import conv_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a; // bus address, value is arbitrary
  localparam int COMMIT = 2000; // long enough to send a second commit while busy
  logic sys_clk_i, nrst_i, scl, sda_low, sda, sda_drv, sda_oe, sel, active, busy, ack;
  logic [7:0] cfg_v, cfg_nv;
  int err_total, total_checks;

  // open drain: pull-up unless either party pulls low
  assign sda = ~(sda_low | (sda_oe & ~sda_drv));

  conv_mode_switch #(.DEV_ADDR(ADDR), .COMMIT_CYCLES(COMMIT)) dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_drv), .sda_oe_o(sda_oe), .config_volatile_o(cfg_v),
    .config_nonvolatile_o(cfg_nv), .single_conversion_select_o(sel),
    .conversion_active_o(active), .nonvolatile_busy_flag_o(busy));
  bus_master m (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic print_verdict();
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // one byte and its expected ack level
  task automatic byte_ack(input logic [7:0] b, input logic exp);
    m.send_byte(b, ack);
    chk_bit(ack, exp);
  endtask : byte_ack

  // start plus our own address with the write bit
  task automatic open_w();
    m.start();
    byte_ack({ADDR, 1'b0}, 1'b1);
  endtask : open_w

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    total_checks = 0;
    nrst_i = 1'b0;
    repeat (16) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk_byte(cfg_nv, CFG_RESET);
    chk_bit(active, 1'b0);
    // single mode first, so the switch below has something to clear
    open_w();
    byte_ack(CONV_CFG_HIGH_OFS, 1'b1);
    byte_ack(8'h81, 1'b1);
    chk_byte(cfg_v, 8'h81);
    chk_bit(sel, 1'b1);
    // switch from single conversions to continuous mode
    open_w();
    byte_ack(CONV_CFG_HIGH_OFS, 1'b1);
    byte_ack(8'hfe, 1'b1);
    chk_bit(sel, 1'b0);
    chk_byte(cfg_nv, CFG_RESET);
    open_w();
    byte_ack(CMD_START_CONV, 1'b1);
    chk_bit(active, 1'b1);
    byte_ack(CMD_COMMIT, 1'b0);
    open_w();
    byte_ack(CMD_COMMIT, 1'b1);
    chk_byte(cfg_nv, 8'hfe);
    chk_bit(busy, 1'b1);
    // a commit while the first is still running is acked and dropped
    open_w();
    byte_ack(CONV_CFG_HIGH_OFS, 1'b1);
    byte_ack(8'h81, 1'b1);
    open_w();
    byte_ack(CMD_COMMIT, 1'b1);
    chk_byte(cfg_nv, 8'hfe);
    chk_bit(busy, 1'b1);
    for (int n = 0; n < COMMIT && busy !== 1'b0; n++) @(negedge sys_clk_i);
    chk_bit(busy, 1'b0);
    // refusals: foreign address, read bit, unknown command
    m.start();
    byte_ack({ADDR ^ 7'h01, 1'b0}, 1'b0);
    m.start();
    byte_ack({ADDR, 1'b1}, 1'b0);
    open_w();
    byte_ack(8'h22, 1'b0);
    m.stop();
    chk_byte(cfg_v, 8'h81);
    chk_byte(cfg_nv, 8'hfe);
    // a reset in mid-run clears every piece of device state
    nrst_i = 1'b0;
    repeat (16) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk_byte(cfg_v, CFG_RESET);
    chk_byte(cfg_nv, CFG_RESET);
    chk_bit(active, 1'b0);
    chk_bit(busy, 1'b0);
    chk_bit(sda_oe, 1'b0);
    // the bus must work again right after the second release
    open_w();
    byte_ack(CMD_START_CONV, 1'b1);
    m.stop();
    chk_bit(active, 1'b1);
    print_verdict();
  end

  // watchdog: the sequence needs well under 10000 clocks
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    err_total++;
    print_verdict();
  end
endmodule : tb_top
